// ===== inc/pump_cmd_regs.vh
`ifndef PUMP_CMD_REGS_VH
`define PUMP_CMD_REGS_VH

// ==========================================
// clock and link timing
`define MCLK_HZ 50000000
`define LINK_BAUD 57600
`define LINK_DATA_BITS 8
`define BAUD_DIV (`MCLK_HZ / `LINK_BAUD)

// ==========================================
// buffers
`define CMD_BUF_DEPTH 8
`define RX_FIFO_DEPTH 8

// ==========================================
// speed limits and reset values
`define SPEED_MIN_RPM 16'h03E8
`define SPEED_MAX_RPM 16'h1770
`define SPEED_RESET 16'h03E8
`define MAINT_NOTE 16'h0000
// firmware release numbers are arbitrary
`define FW_MAJOR 16'h0000
`define FW_MINOR 16'h0001

// ==========================================
// characters
`define CH_CR 8'h0D
`define CH_LF 8'h0A
`define CH_ZERO 8'h30
`define CH_ONE 8'h31
`define CH_NINE 8'h39
`define CH_QUERY 8'h3F
`define CH_SEMI 8'h3B
`define CH_COMMA 8'h2C
`define CH_DOT 8'h2E
`define CH_LD 8'h64
`define CH_LG 8'h67
`define CH_LP 8'h70
`define CH_LI 8'h69
`define CH_LL 8'h6C
`define CH_LH 8'h68
`define CH_UB 8'h42
`define CH_UE 8'h45
`define CH_US 8'h53
`define CH_UP 8'h50
`define CH_UV 8'h56

`endif

// ===== src/char_fifo.v
`timescale 1ns/1ps

module char_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8
) (
  input wire mclk,
  input wire rst_b,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);

  localparam AW = $clog2(DEPTH);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;

  // ==========================================
  // handshakes
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  // ==========================================
  // storage
  always @(posedge mclk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd & ~do_wr) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // char_fifo

// ===== src/pump_motor_serial_commands.v
`timescale 1ns/1ps
`include "pump_cmd_regs.vh"

module pump_motor_serial_commands (
  input wire mclk,
  input wire rst_b,
  input wire [7:0] rx_data,
  input wire rx_valid,
  output wire rx_ready,
  output reg [7:0] tx_data,
  output wire tx_valid,
  input wire tx_ready,
  output reg baud_tick,
  input wire wired_run,
  input wire [15:0] actual_speed_value,
  input wire [15:0] motor_current_ma,
  input wire [15:0] controller_temp_c,
  input wire [15:0] fault_word,
  output reg motor_run,
  output reg [15:0] target_speed_value,
  output reg serial_control
);

  // ==========================================
  // states and command codes
  localparam [3:0] S_COLLECT = 4'h0;
  localparam [3:0] S_DECODE = 4'h1;
  localparam [3:0] S_PARSE = 4'h2;
  localparam [3:0] S_EXEC = 4'h3;
  localparam [3:0] S_FIELD = 4'h4;
  localparam [3:0] S_DIGIT = 4'h5;
  localparam [3:0] S_NEXT = 4'h6;
  localparam [3:0] S_ACK = 4'h7;
  localparam [3:0] S_CR = 4'h8;
  localparam [3:0] S_TX = 4'h9;

  localparam [3:0] C_BAD = 4'h0;
  localparam [3:0] C_RUN = 4'h1;
  localparam [3:0] C_HALT = 4'h2;
  localparam [3:0] C_SPEED = 4'h3;
  localparam [3:0] C_POLL = 4'h4;
  localparam [3:0] C_FAULT = 4'h5;
  localparam [3:0] C_TGT = 4'h6;
  localparam [3:0] C_FLOOR = 4'h7;
  localparam [3:0] C_CEIL = 4'h8;
  localparam [3:0] C_FW = 4'h9;

  localparam integer BAUD_LAST = `BAUD_DIV - 1;
  localparam integer BUF_FULL = `CMD_BUF_DEPTH;

  // ==========================================
  // functions
  function [15:0] pow10;
    input [2:0] p;
    begin
      case (p)
        3'h0: pow10 = 16'h2710;
        3'h1: pow10 = 16'h03E8;
        3'h2: pow10 = 16'h0064;
        3'h3: pow10 = 16'h000A;
        default: pow10 = 16'h0001;
      endcase
    end
  endfunction

  function [2:0] field_count;
    input [3:0] c;
    begin
      case (c)
        C_POLL: field_count = 3'h4;
        C_FW: field_count = 3'h2;
        default: field_count = 3'h1;
      endcase
    end
  endfunction

  function is_digit;
    input [7:0] ch;
    begin
      is_digit = (ch >= `CH_ZERO) && (ch <= `CH_NINE);
    end
  endfunction

  // ==========================================
  // storage
  reg [7:0] cmd_buf [0:`CMD_BUF_DEPTH-1];
  reg [3:0] buf_len;
  reg overflow;
  reg [3:0] state;
  reg [3:0] ret_state;
  reg [3:0] cmd;
  reg [3:0] idx;
  reg [19:0] acc;
  reg arg_bad;
  reg arg_frac;
  reg arg_big;
  reg [7:0] ack;
  reg [2:0] fidx;
  reg [15:0] rem;
  reg [2:0] pos;
  reg [3:0] digit;
  reg started;
  reg serial_run;
  reg [2:0] run_sync;
  reg wired_level;
  reg [9:0] baud_cnt;

  wire [7:0] fifo_data;
  wire fifo_valid;
  wire fifo_take;
  wire [15:0] cur_pow;
  wire lead_ok;
  wire [7:0] pchar;
  wire [3:0] pdig;
  wire [19:0] next_acc;

  reg [15:0] fval;
  reg [7:0] fsep;
  reg [2:0] fmin;

  // ==========================================
  // receive buffering, stalls while replying
  char_fifo #(
    .WIDTH(`LINK_DATA_BITS),
    .DEPTH(`RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .in_data(rx_data),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_take)
  );

  assign fifo_take = (state == S_COLLECT);
  assign tx_valid = (state == S_TX);
  assign cur_pow = pow10(pos);
  assign lead_ok = ({1'b0, pos} + {1'b0, fmin}) >= 4'h5;
  assign pchar = cmd_buf[idx[2:0]];
  assign pdig = pchar[3:0];
  assign next_acc = acc * 20'h0000A + {16'h0000, pdig};

  // ==========================================
  // bit rate tick for the serial engine
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      baud_cnt <= 10'h000;
      baud_tick <= 1'b0;
    end else if (baud_cnt == BAUD_LAST[9:0]) begin
      baud_cnt <= 10'h000;
      baud_tick <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt + 10'h001;
      baud_tick <= 1'b0;
    end
  end

  // ==========================================
  // wired run input, filtered pin
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      run_sync <= 3'h0;
      wired_level <= 1'b0;
      motor_run <= 1'b0;
    end else begin
      run_sync <= {run_sync[1:0], wired_run};
      if (run_sync[2] == run_sync[1]) begin
        wired_level <= run_sync[2];
      end
      // serial ownership is sticky so a stray wired level cannot restart a halted motor
      motor_run <= serial_control ? serial_run : wired_level;
    end
  end

  // ==========================================
  // reply field selection
  always @* begin
    fval = `MAINT_NOTE;
    fsep = `CH_SEMI;
    fmin = 3'h1;
    case (cmd)
      C_SPEED, C_TGT: fval = target_speed_value;
      C_FAULT: fval = fault_word;
      C_FLOOR: fval = `SPEED_MIN_RPM;
      C_CEIL: fval = `SPEED_MAX_RPM;
      C_POLL: begin
        case (fidx)
          3'h0: fval = actual_speed_value;
          3'h1: fval = motor_current_ma;
          3'h2: fval = controller_temp_c;
          default: fval = fault_word;
        endcase
        if (fidx != 3'h0) begin
          fsep = `CH_COMMA;
        end
      end
      C_FW: begin
        if (fidx == 3'h0) begin
          fval = `FW_MAJOR;
          fsep = `CH_DOT;
          fmin = 3'h2;
        end else begin
          fval = `FW_MINOR;
          fmin = 3'h3;
        end
      end
      default: fval = `MAINT_NOTE;
    endcase
  end

  // ==========================================
  // command engine
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_COLLECT;
      ret_state <= S_COLLECT;
      buf_len <= 4'h0;
      overflow <= 1'b0;
      cmd <= C_BAD;
      idx <= 4'h0;
      acc <= 20'h00000;
      arg_bad <= 1'b0;
      arg_frac <= 1'b0;
      arg_big <= 1'b0;
      ack <= `CH_QUERY;
      fidx <= 3'h0;
      rem <= 16'h0000;
      pos <= 3'h0;
      digit <= 4'h0;
      started <= 1'b0;
      tx_data <= 8'h00;
      serial_run <= 1'b0;
      serial_control <= 1'b0;
      target_speed_value <= `SPEED_RESET;
    end else begin
      case (state)
        S_COLLECT: begin
          if (fifo_valid) begin
            if (fifo_data == `CH_CR) begin
              state <= S_DECODE;
            end else if (fifo_data == `CH_LF) begin
              state <= S_COLLECT;
            end else if (buf_len != BUF_FULL[3:0]) begin
              cmd_buf[buf_len[2:0]] <= fifo_data;
              buf_len <= buf_len + 4'h1;
            end else begin
              overflow <= 1'b1;
            end
          end
        end
        S_DECODE: begin
          idx <= 4'h2;
          acc <= 20'h00000;
          arg_bad <= 1'b0;
          arg_frac <= 1'b0;
          arg_big <= 1'b0;
          fidx <= 3'h0;
          state <= S_EXEC;
          cmd <= C_BAD;
          if (overflow) begin
            cmd <= C_BAD;
          end else if (buf_len == 4'h2) begin
            if (cmd_buf[0] == `CH_LD && cmd_buf[1] == `CH_UB) cmd <= C_RUN;
            if (cmd_buf[0] == `CH_LD && cmd_buf[1] == `CH_UE) cmd <= C_HALT;
            if (cmd_buf[0] == `CH_LP && cmd_buf[1] == `CH_UP) cmd <= C_POLL;
            if (cmd_buf[0] == `CH_LG && cmd_buf[1] == `CH_UP) cmd <= C_FAULT;
            if (cmd_buf[0] == `CH_LG && cmd_buf[1] == `CH_US) cmd <= C_TGT;
            if (cmd_buf[0] == `CH_LI && cmd_buf[1] == `CH_UV) cmd <= C_FW;
          end else if (buf_len > 4'h2) begin
            if (cmd_buf[0] == `CH_LD && cmd_buf[1] == `CH_US) begin
              cmd <= C_SPEED;
              state <= S_PARSE;
            end else if (buf_len == 4'h3 && cmd_buf[0] == `CH_LG && cmd_buf[1] == `CH_US) begin
              if (cmd_buf[2] == `CH_LL) cmd <= C_FLOOR;
              if (cmd_buf[2] == `CH_LH) cmd <= C_CEIL;
            end
          end
        end
        S_PARSE: begin
          if (idx == buf_len) begin
            state <= S_EXEC;
          end else begin
            idx <= idx + 4'h1;
            if (is_digit(pchar)) begin
              if (!arg_big && !arg_frac) begin
                acc <= next_acc;
                if (next_acc > 20'h0FFFF) arg_big <= 1'b1;
              end
            end else if (pchar == `CH_DOT) begin
              arg_frac <= 1'b1;
            end else begin
              arg_bad <= 1'b1;
            end
          end
        end
        S_EXEC: begin
          ack <= `CH_ONE;
          state <= S_FIELD;
          case (cmd)
            C_RUN: begin
              serial_control <= 1'b1;
              serial_run <= 1'b1;
            end
            C_HALT: begin
              serial_control <= 1'b1;
              serial_run <= 1'b0;
            end
            C_SPEED: begin
              if (arg_bad) begin
                ack <= `CH_QUERY;
                state <= S_ACK;
              end else if (arg_frac || arg_big) begin
                ack <= `CH_ZERO;
              end else if (acc < {4'h0, `SPEED_MIN_RPM} || acc > {4'h0, `SPEED_MAX_RPM}) begin
                ack <= `CH_ZERO;
              end else begin
                serial_control <= 1'b1;
                target_speed_value <= acc[15:0];
              end
            end
            C_BAD: begin
              ack <= `CH_QUERY;
              state <= S_ACK;
            end
            default: ack <= `CH_ONE;
          endcase
        end
        S_FIELD: begin
          rem <= fval;
          pos <= 3'h0;
          digit <= 4'h0;
          started <= 1'b0;
          state <= S_DIGIT;
        end
        S_DIGIT: begin
          if (rem >= cur_pow) begin
            rem <= rem - cur_pow;
            digit <= digit + 4'h1;
          end else if (digit != 4'h0 || started || lead_ok) begin
            tx_data <= `CH_ZERO + {4'h0, digit};
            started <= 1'b1;
            ret_state <= S_NEXT;
            state <= S_TX;
          end else begin
            state <= S_NEXT;
          end
        end
        S_NEXT: begin
          digit <= 4'h0;
          if (pos == 3'h4) begin
            tx_data <= fsep;
            fidx <= fidx + 3'h1;
            ret_state <= (fidx == field_count(cmd) - 3'h1) ? S_ACK : S_FIELD;
            state <= S_TX;
          end else begin
            pos <= pos + 3'h1;
            state <= S_DIGIT;
          end
        end
        S_ACK: begin
          tx_data <= ack;
          ret_state <= S_CR;
          state <= S_TX;
        end
        S_CR: begin
          tx_data <= `CH_CR;
          buf_len <= 4'h0;
          overflow <= 1'b0;
          ret_state <= S_COLLECT;
          state <= S_TX;
        end
        S_TX: begin
          // no timeout on the sender: a stalled serial engine holds the reply
          if (tx_ready) begin
            state <= ret_state;
          end
        end
        default: state <= S_COLLECT;
      endcase
    end
  end

endmodule // pump_motor_serial_commands

// ===== tb/pump_cmd_monitor.sv
`timescale 1ns/1ps
`include "pump_cmd_regs.vh"
// ==========
// port checker
module pump_cmd_monitor (
  input wire mclk,
  input wire rst_b,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire rx_ready,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_ready,
  input wire baud_tick,
  input wire wired_run,
  input wire [15:0] actual_speed_value,
  input wire [15:0] motor_current_ma,
  input wire [15:0] controller_temp_c,
  input wire [15:0] fault_word,
  input wire motor_run,
  input wire [15:0] target_speed_value,
  input wire serial_control
);
  reg [9:0] gap;
  reg seen;
  // first tick after reset has no reference, so gap checks wait for it
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gap <= 10'h000;
      seen <= 1'b0;
    end else begin
      gap <= baud_tick ? 10'h000 : gap + 10'h001;
      seen <= seen | baud_tick;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_tx_char_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply char changed before take");
  a_tx_take_drop: assert property (tx_valid && tx_ready |=> !tx_valid)
    else $error("reply char offered again after take");
  a_baud_tick_gap: assert property (seen |-> gap < `BAUD_DIV && (!baud_tick || gap == `BAUD_DIV - 1))
    else $error("bit rate tick spacing wrong");
  a_reply_char_set: assert property (tx_valid |-> tx_data inside {[`CH_ZERO:`CH_NINE], `CH_SEMI, `CH_COMMA, `CH_DOT,
    `CH_QUERY, `CH_CR})
    else $error("reply char outside digit set");
  a_target_in_limits: assert property (target_speed_value inside {[`SPEED_MIN_RPM:`SPEED_MAX_RPM]})
    else $error("nominal speed outside limits");
  a_serial_ctl_sticky: assert property (serial_control |=> serial_control)
    else $error("serial control dropped");
  a_target_by_serial: assert property ($changed(target_speed_value) |-> ##[0:1] serial_control)
    else $error("nominal speed moved without serial command");
  a_wired_run_follow: assert property ((!serial_control && $stable(wired_run))[*6] |-> motor_run == wired_run)
    else $error("motor run not following wired input");
endmodule // pump_cmd_monitor

bind pump_motor_serial_commands pump_cmd_monitor i_pump_cmd_monitor (.mclk(mclk), .rst_b(rst_b),
  .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .baud_tick(baud_tick), .wired_run(wired_run), .actual_speed_value(actual_speed_value),
  .motor_current_ma(motor_current_ma), .controller_temp_c(controller_temp_c), .fault_word(fault_word),
  .motor_run(motor_run), .target_speed_value(target_speed_value), .serial_control(serial_control));

// ===== tb/host_link.sv
`timescale 1ns/1ps
// ==========
// terminal side of the character streams
module host_link (
  input wire mclk,
  input wire rst_b,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire rx_ready,
  input wire [7:0] tx_data,
  input wire tx_valid,
  output logic tx_ready,
  input wire stall,
  input wire slow
);
  logic [7:0] send_q[$];
  string got;
  int crs;
  // the pause after a start is kept by the scenarios, scaled down to keep runs short
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
    got = "";
    crs = 0;
  end
  always @(posedge mclk) begin
    if (rst_b && (!rx_valid || rx_ready)) begin
      if (send_q.size() > 0) begin
        rx_valid <= 1'b1;
        rx_data <= send_q.pop_front();
      end else begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data; // idle line alternates the last char with its inverse
      end
    end
    if (tx_valid && tx_ready) begin
      got = {got, string'(tx_data)};
      if (tx_data == 8'h0D)
        crs = crs + 1;
    end
    tx_ready <= rst_b && !stall && (!slow || !tx_ready);
  end
endmodule // host_link

// ===== tb/pump_motor_serial_commands_tb_top.sv
`timescale 1ns/1ps
`include "pump_cmd_regs.vh"
module pump_motor_serial_commands_tb_top;
  reg mclk = 0, rst_b = 0, wired_run = 0, stall = 0, slow = 0;
  reg [15:0] spd = 16'h0960, cur = 16'h015E, tmp = 16'h0029, flt = 16'hFFFF;
  wire [7:0] rx_data, tx_data;
  wire rx_valid, rx_ready, tx_valid, tx_ready, baud_tick, motor_run, serial_control;
  wire [15:0] target_speed_value;
  integer mismatches = 0, samples_checked = 0, cycles = 0;
  always #10 mclk = ~mclk;
  pump_motor_serial_commands i_pump_motor_serial_commands (.mclk(mclk), .rst_b(rst_b), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .baud_tick(baud_tick), .wired_run(wired_run), .actual_speed_value(spd), .motor_current_ma(cur),
    .controller_temp_c(tmp), .fault_word(flt), .motor_run(motor_run), .target_speed_value(target_speed_value),
    .serial_control(serial_control));
  host_link i_host_link (.mclk(mclk), .rst_b(rst_b), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .stall(stall), .slow(slow));
  // ==========
  // report and compare
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task check_str(input string what, input string exp, input string got);
    samples_checked++;
    if (exp != got) begin
      mismatches++;
      $display("unexpected %s: expected %s seen %s", what, exp, got);
    end
  endtask
  task check_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask
  task xfer(input string cmd, input string exp);
    int i, n;
    i_host_link.got = "";
    n = i_host_link.crs;
    for (i = 0; i < cmd.len(); i++)
      i_host_link.send_q.push_back(cmd[i]);
    i_host_link.send_q.push_back(`CH_CR);
    i = 0;
    while (i_host_link.crs == n && i < 4000) begin
      @(posedge mclk);
      i++;
    end
    check_str(cmd, exp, i_host_link.got);
  endtask
  // ==========
  // scenarios
  task t_wired;
    wired_run <= 1'b1;
    repeat (10) @(posedge mclk);
    check_bit("motor_run", 1'b1, motor_run);
    wired_run <= 1'b0;
    repeat (10) @(posedge mclk);
    check_bit("motor_run", 1'b0, motor_run);
    $display("test wired done");
  endtask
  task t_motor;
    xfer({"d", "B"}, "0;1\r");
    check_bit("motor_run", 1'b1, motor_run);
    check_bit("serial_control", 1'b1, serial_control);
    repeat (100) @(posedge mclk); // host pause after start, shortened
    wired_run <= 1'b1;
    xfer({"d", "E"}, "0;1\r");
    repeat (10) @(posedge mclk);
    check_bit("motor_run", 1'b0, motor_run);
    wired_run <= 1'b0;
    $display("test motor done");
  endtask
  task t_speed;
    string arg[9] = '{"2500", "6000", "6001", "999", "1000", "25.5", "70000", "2x", ""};
    string exp[9] = '{"2500;1\r", "6000;1\r", "6000;0\r", "6000;0\r", "1000;1\r", "1000;0\r", "1000;0\r",
      "?\r", "?\r"};
    for (int i = 0; i < 9; i++)
      xfer({"d", "S", arg[i]}, exp[i]);
    xfer({"g", "S"}, "1000;1\r");
    check_str("target_speed_value", "1000", $sformatf("%0d", target_speed_value));
    $display("test speed done");
  endtask
  task t_reads;
    xfer({"p", "P"}, $sformatf("%0d;%0d,%0d,%0d,1\r", spd, cur, tmp, flt));
    xfer({"g", "P", "\n"}, "65535;1\r");
    xfer({"g", "S", "l"}, $sformatf("%0d;1\r", `SPEED_MIN_RPM));
    xfer({"g", "S", "h"}, $sformatf("%0d;1\r", `SPEED_MAX_RPM));
    xfer({"i", "V"}, $sformatf("%02d.%03d;1\r", `FW_MAJOR, `FW_MINOR));
    xfer({"x", "Q"}, "?\r");
    xfer("1234567890", "?\r");
    $display("test reads done");
  endtask
  task t_fill;
    int i, n;
    // replies stalled, so the queued commands pile up in the fifo
    stall <= 1'b1;
    flt <= 16'h0005;
    i_host_link.got = "";
    n = i_host_link.crs;
    for (i = 0; i < 4; i++)
      i_host_link.send_q = {i_host_link.send_q, `CH_LG, `CH_UP, `CH_CR};
    i = 0;
    while (rx_ready !== 1'b0 && i < 300) begin
      @(posedge mclk);
      i++;
    end
    check_bit("rx_ready", 1'b0, rx_ready);
    stall <= 1'b0;
    slow <= 1'b1;
    i = 0;
    while (i_host_link.crs < n + 4 && i < 8000) begin
      @(posedge mclk);
      i++;
    end
    check_str("queued replies", "5;1\r5;1\r5;1\r5;1\r", i_host_link.got);
    slow <= 1'b0;
    $display("test fill done");
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      print_verdict;
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    t_wired;
    t_motor;
    t_speed;
    t_reads;
    t_fill;
    print_verdict;
  end
endmodule // pump_motor_serial_commands_tb_top
